// >>> qrc_defines.svh
// numeric constants of the qpi read-config / reset / discoverable-parameter block
`ifndef QRC_DEFINES_SVH
`define QRC_DEFINES_SVH
`define QRC_OP_SET_PARAMS 8'hC0
`define QRC_OP_SET_WRAP 8'h77
`define QRC_OP_WRAP_READ 8'h0C
`define QRC_OP_WRAP_LOW 8'h8C
`define QRC_OP_WRAP_HIGH 8'h8D
`define QRC_OP_QPI_ON 8'h38
`define QRC_OP_QPI_OFF 8'hFF
`define QRC_OP_RST_EN 8'h66
`define QRC_OP_RST 8'h99
`define QRC_OP_PARAM_READ 8'h5A
`define QRC_OP_SUSPEND 8'h75
`define QRC_DUMMY_SHORT 4'h4
`define QRC_DUMMY_MID 4'h6
`define QRC_DUMMY_LONG 4'h8
`define QRC_PARAM_DUMMY 4'h8
`define QRC_BYTE_BITS 4'h8
`define QRC_ADDR_LAST 2'h2
`define QRC_TOP_BIT 24
`define QRC_WRAP_BASE 25'h0000008
`define QRC_PARAMS_RST 8'h00
`define QRC_WRAP_BITS_RST 3'h7
`define QRC_WRAP_SEL_RST 2'h0
`define QRC_CLK_PERIOD_NS 8
`define QRC_RST_RECOVERY_NS 30000
`define QRC_RST_CYCLES ((`QRC_RST_RECOVERY_NS + `QRC_CLK_PERIOD_NS - 1) / `QRC_CLK_PERIOD_NS)
`define QRC_TABLE_END 5'h18
`endif

// >>> qrc_pkg.sv
// types shared by the qpi read-config / reset / discoverable-parameter block
package qrc_pkg;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_PARAM, PH_IGNORE} qrc_phase_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } qrc_pins_t;
  typedef struct packed {
    qrc_pins_t s1;
    qrc_pins_t s2;
    logic sclk_d;
    qrc_phase_t phase;
    logic [7:0] op;
    logic [7:0] shin;
    logic [3:0] bitcnt;
    logic [1:0] bytecnt;
    logic [3:0] dcnt;
    logic [24:0] addr;
    logic mreq;
    logic sreq;
    logic [7:0] shout;
    logic [3:0] outcnt;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic qpi;
    logic [7:0] read_params;
    logic [2:0] wrap_bits;
    logic [1:0] wrap_sel;
    logic armed;
    logic [11:0] rcnt;
    logic rst_busy;
    logic clear_vol;
    logic susp_req;
  } qrc_state_t;
endpackage

// >>> qrc_core.sv
// serial command front end: read parameters, wrap reads, qpi switch, reset, parameter table
// How it works
// - qpi set-parameters sets read dummy clocks
// - dummy 4/6/8/8, wrap 8/16/32/64 bytes
// - spi wrap length from set-wrap bits
// - wrap setting survives entry into qpi
// - wrap read wraps inside aligned window
// - wrap reads use programmed length and dummies
// - low-half wrap read forces top bit 0
// - high-half wrap read forces top bit 1
// - enable-qpi switches interface to qpi
// - disable-qpi returns interface to spi
// - mode switch keeps suspend, wrap; clears reset latch
// - reset clears all volatile settings, aborts
// - reset pair accepted in spi and qpi
// - commands ignored during reset recovery
// - parameter read: address then table bytes
// - bytes 4-7 give revision, count, filler
// - first header: id, rev, length, pointer
// - suspend only when idle-suspend and busy
`timescale 1ns/10ps
`include "qrc_defines.svh"

module qrc_fifo
  import qrc_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } qrc_fifo_st_t;
  qrc_fifo_st_t r;
  qrc_fifo_st_t n;
  logic push;
  logic pop;
  assign o_in_ready = r.cnt != (AW+1)'(D);
  assign o_out_valid = r.cnt != '0;
  assign o_out_data = r.mem[r.rp];
  always_comb begin
    n = r;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (push) begin
      n.mem[r.wp] = i_in_data;
      n.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

module qrc_core
  import qrc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  output logic o_mem_req,
  output logic [24:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  input wire logic i_suspend,
  input wire logic i_wip,
  output logic o_suspend_req,
  output logic o_clear_volatile,
  output logic o_reset_busy,
  output logic o_qpi,
  output logic [7:0] o_read_params,
  output logic [2:0] o_wrap_bits
);
  qrc_state_t r;
  qrc_state_t n;
  logic rise, fall, cs, wq, byte_done, fetching, is_param, take;
  logic push_v, pop, f_ready, f_valid, flush;
  logic [3:0] bits_n, dummy_need;
  logic [7:0] shin_n, push_d, f_data, rom;
  logic [24:0] mask, next_addr;

  // parameter table; pointer 30h/60h headers, unmapped bytes read as ff
  localparam logic [0:23][7:0] param_table = {
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    MAKER_CODE, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  assign rom = (r.addr[23:5] == '0 && r.addr[4:0] < `QRC_TABLE_END) ?
    param_table[r.addr[4:0]] : 8'hFF;

  assign rise = r.s2.sclk && !r.sclk_d;
  assign fall = !r.s2.sclk && r.sclk_d;
  assign cs = !r.s2.cs_n;
  // set-wrap carries its address and wrap byte on four lines even in spi
  assign wq = r.qpi || (r.phase != PH_CMD && r.op == `QRC_OP_SET_WRAP);
  assign bits_n = r.bitcnt + (wq ? 4'h4 : 4'h1);
  assign byte_done = bits_n == `QRC_BYTE_BITS;
  assign shin_n = wq ? {r.shin[3:0], r.s2.io} : {r.shin[6:0], r.s2.io[0]};
  assign take = cs && rise && byte_done && r.phase == PH_CMD && !r.rst_busy;
  assign is_param = r.op == `QRC_OP_PARAM_READ;
  assign fetching = cs && (r.phase == PH_DUMMY || r.phase == PH_DATA);
  assign push_v = fetching && (is_param ? r.sreq : (r.mreq && i_mem_ack));
  assign push_d = is_param ? rom : i_mem_data;
  assign pop = cs && fall && r.phase == PH_DATA && r.outcnt == '0 && f_valid;
  assign flush = !cs;
  assign mask = (`QRC_WRAP_BASE << r.wrap_sel) - 25'h1;

  always_comb begin
    case (r.read_params[5:4])
      2'b00: dummy_need = `QRC_DUMMY_SHORT;
      2'b01: dummy_need = `QRC_DUMMY_MID;
      default: dummy_need = `QRC_DUMMY_LONG;
    endcase
    if (is_param) begin
      dummy_need = `QRC_PARAM_DUMMY;
      next_addr = r.addr + 25'h1;
    end else begin
      next_addr = (r.addr & ~mask) | ((r.addr + 25'h1) & mask);
    end
    if (r.op == `QRC_OP_WRAP_LOW) begin
      next_addr[`QRC_TOP_BIT] = 1'b0;
    end else if (r.op == `QRC_OP_WRAP_HIGH) begin
      next_addr[`QRC_TOP_BIT] = 1'b1;
    end
  end

  qrc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_flush(flush),
    .i_in_valid(push_v),
    .o_in_ready(f_ready),
    .i_in_data(push_d),
    .o_out_valid(f_valid),
    .i_out_ready(pop),
    .o_out_data(f_data)
  );

  always_comb begin
    n = r;
    n.s1 = '{sclk: i_sclk, cs_n: i_cs_n, io: i_io};
    n.s2 = r.s1;
    n.sclk_d = r.s2.sclk;
    n.clear_vol = 1'b0;
    n.susp_req = 1'b0;
    if (r.rst_busy) begin
      n.rcnt = r.rcnt - 12'h1;
      n.rst_busy = r.rcnt != 12'h1;
    end
    // one outstanding fetch, issued only with room, so an ack always fits
    if (push_v) begin
      n.mreq = 1'b0;
      n.sreq = 1'b0;
      n.addr = next_addr;
    end else if (fetching && !r.mreq && !r.sreq && f_ready) begin
      n.mreq = !is_param;
      n.sreq = is_param;
    end
    if (!cs) begin
      n.phase = PH_CMD;
      n.bitcnt = '0;
      n.bytecnt = '0;
      n.outcnt = '0;
      n.io_oe = '0;
      n.mreq = 1'b0;
      n.sreq = 1'b0;
    end else if (rise && r.phase != PH_DATA && r.phase != PH_IGNORE) begin
      n.shin = shin_n;
      n.bitcnt = byte_done ? 4'h0 : bits_n;
      case (r.phase)
        PH_CMD: begin
          if (byte_done) begin
            n.phase = PH_IGNORE;
            n.op = shin_n;
          end
          if (take) begin
            n.armed = shin_n == `QRC_OP_RST_EN;
            case (shin_n)
              `QRC_OP_WRAP_READ, `QRC_OP_WRAP_LOW, `QRC_OP_WRAP_HIGH:
                n.phase = r.qpi ? PH_ADDR : PH_IGNORE;
              `QRC_OP_PARAM_READ: n.phase = PH_ADDR;
              `QRC_OP_SET_WRAP: n.phase = r.qpi ? PH_IGNORE : PH_ADDR;
              `QRC_OP_SET_PARAMS: n.phase = r.qpi ? PH_PARAM : PH_IGNORE;
              // the mode flag moves and the reset latch clears; suspend, wrap stay
              `QRC_OP_QPI_ON: n.qpi = 1'b1;
              `QRC_OP_QPI_OFF: n.qpi = 1'b0;
              `QRC_OP_SUSPEND: n.susp_req = !i_suspend && i_wip;
              `QRC_OP_RST: begin
                if (r.armed) begin
                  n.qpi = 1'b0;
                  n.read_params = `QRC_PARAMS_RST;
                  n.wrap_bits = `QRC_WRAP_BITS_RST;
                  n.wrap_sel = `QRC_WRAP_SEL_RST;
                  n.clear_vol = 1'b1;
                  n.rst_busy = 1'b1;
                  n.rcnt = 12'(`QRC_RST_CYCLES);
                end
              end
              default: n.phase = PH_IGNORE;
            endcase
          end
        end
        PH_ADDR: begin
          if (byte_done) begin
            n.addr = {1'b0, r.addr[15:0], shin_n};
            n.bytecnt = r.bytecnt + 2'h1;
            if (r.bytecnt == `QRC_ADDR_LAST) begin
              n.dcnt = '0;
              n.phase = (r.op == `QRC_OP_SET_WRAP) ? PH_PARAM : PH_DUMMY;
              n.addr[`QRC_TOP_BIT] = r.op == `QRC_OP_WRAP_HIGH;
            end
          end
        end
        PH_DUMMY: begin
          n.bitcnt = '0;
          n.dcnt = r.dcnt + 4'h1;
          if (r.dcnt + 4'h1 == dummy_need) begin
            n.phase = PH_DATA;
          end
        end
        PH_PARAM: begin
          if (byte_done) begin
            n.phase = PH_IGNORE;
            if (r.op == `QRC_OP_SET_PARAMS) begin
              n.read_params = shin_n;
              n.wrap_sel = shin_n[1:0];
            end else begin
              n.wrap_bits = shin_n[6:4];
              n.wrap_sel = shin_n[6:5];
            end
          end
        end
        default: n.phase = r.phase;
      endcase
    end
    // data leaves on the falling edge so the host samples it on the rising one
    if (cs && fall && r.phase == PH_DATA) begin
      n.io_oe = r.qpi ? 4'hF : 4'h2;
      if (r.outcnt == '0) begin
        if (f_valid) begin
          n.io_out = r.qpi ? f_data[7:4] : {2'b00, f_data[7], 1'b0};
          n.shout = r.qpi ? {f_data[3:0], 4'h0} : {f_data[6:0], 1'b0};
          n.outcnt = r.qpi ? 4'h4 : 4'h7;
        end
      end else begin
        n.io_out = r.qpi ? r.shout[7:4] : {2'b00, r.shout[7], 1'b0};
        n.shout = r.qpi ? {r.shout[3:0], 4'h0} : {r.shout[6:0], 1'b0};
        n.outcnt = r.outcnt - (r.qpi ? 4'h4 : 4'h1);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r <= '0;
      r.s1.cs_n <= 1'b1;
      r.s2.cs_n <= 1'b1;
      r.read_params <= `QRC_PARAMS_RST;
      r.wrap_bits <= `QRC_WRAP_BITS_RST;
      r.wrap_sel <= `QRC_WRAP_SEL_RST;
    end else begin
      r <= n;
    end
  end

  assign o_io_out = r.io_out;
  assign o_io_oe = r.io_oe;
  assign o_mem_req = r.mreq;
  assign o_mem_addr = r.addr;
  assign o_suspend_req = r.susp_req;
  assign o_clear_volatile = r.clear_vol;
  assign o_reset_busy = r.rst_busy;
  assign o_qpi = r.qpi;
  assign o_read_params = r.read_params;
  assign o_wrap_bits = r.wrap_bits;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_qpi_enter: assert property (take && shin_n == `QRC_OP_QPI_ON |=> r.qpi)
    else $error("enable-qpi did not set qpi");
  a_qpi_leave: assert property (take && shin_n == `QRC_OP_QPI_OFF |=> !r.qpi)
    else $error("disable-qpi did not clear qpi");
  a_mode_keeps: assert property ($changed(r.qpi) && !r.clear_vol |-> $stable(r.wrap_sel))
    else $error("mode switch altered wrap setting");
  a_reset_clear: assert property (take && shin_n == `QRC_OP_RST && r.armed |=>
    r.read_params == `QRC_PARAMS_RST && r.clear_vol && r.rst_busy && !r.qpi)
    else $error("reset left volatile state");
  a_reset_deaf: assert property (r.rst_busy && r.phase == PH_CMD && cs |=>
    !$changed(r.read_params) && !r.susp_req)
    else $error("command taken during reset recovery");
  a_dummy_six: assert property (r.read_params[5:4] == 2'b01 && !is_param |-> dummy_need == 4'h6)
    else $error("dummy decode wrong");
  a_low_half: assert property (r.mreq && r.op == `QRC_OP_WRAP_LOW |-> !r.addr[24])
    else $error("low-half read left lower half");
  a_high_half: assert property (r.mreq && r.op == `QRC_OP_WRAP_HIGH |-> r.addr[24])
    else $error("high-half read left upper half");
  a_wrap_window: assert property (push_v && !is_param |=> (r.addr & ~mask) ==
    ($past(r.addr) & ~mask))
    else $error("wrap read left its window");
  a_suspend_gate: assert property (r.susp_req |-> $past(i_wip) && !$past(i_suspend))
    else $error("suspend passed while not allowed");
endmodule

// >>> qrc_host_model.sv
// host serial controller model that drives the link pins
`timescale 1ns/10ps
module qrc_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_wire
);
  // serial clock rests low between frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end

  // one link clock: drive, rise and sample, fall
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    o_io = v;
    #62.5 o_sclk = 1'b1;
    s = i_wire;
    #62.5 o_sclk = 1'b0;
  endtask

  // released lines flip each clock so a stale level never reads as data
  task automatic xfer(input logic [7:0] b, input logic q, input logic rel,
                      output logic [7:0] r);
    logic [3:0] s;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      tick(rel ? ~o_io : (q ? b[7-4*i -: 4] : {3'h5, b[7-i]}), s);
      r = q ? {r[3:0], s} : {r[6:0], s[1]};
    end
  endtask

  task automatic dummy;
    logic [3:0] s;
    tick(~o_io, s);
  endtask

  // each command gets a frame of its own, gap of 25 system clocks
  task automatic cs(input logic v);
    #62.5 o_cs_n = v;
    if (v)
      #200;
  endtask
endmodule

// >>> test_qrc_core.sv
// self-checking bench for the serial command front end
`timescale 1ns/10ps
module test_qrc_core;
  import qrc_pkg::*;
  localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
  logic i_clock;
  logic i_rst;
  logic i_mem_ack;
  logic [7:0] i_mem_data;
  logic i_suspend;
  logic i_wip;
  logic sclk, cs_n, mem_req, clr, busy, qpi, susp;
  logic slow = 1'b0;
  logic [3:0] h_io, io_out, io_oe, wire_io;
  logic [24:0] mem_addr;
  logic [7:0] params, r;
  logic [2:0] wbits;
  logic [24:0] aq[$];
  logic [7:0] cp[4] = '{8'h00, 8'h13, 8'h22, 8'h31};
  logic [7:0] cop[4] = '{8'h0C, 8'h8D, 8'h8C, 8'h8D};
  int cnd[4] = '{4, 6, 8, 8};
  int cw[4] = '{8, 64, 32, 16};
  int err_count = 0;
  int n_checks = 0;
  int n_clr = 0;
  int n_susp = 0;
  int wt = 0;

  qrc_core #(.MAKER_CODE(MAKER), .FIFO_DEPTH(8)) DUT (.i_clock(i_clock), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_io(wire_io), .o_io_out(io_out), .o_io_oe(io_oe),
    .o_mem_req(mem_req), .o_mem_addr(mem_addr), .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data), .i_suspend(i_suspend), .i_wip(i_wip), .o_suspend_req(susp),
    .o_clear_volatile(clr), .o_reset_busy(busy), .o_qpi(qpi), .o_read_params(params),
    .o_wrap_bits(wbits));
  qrc_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .i_wire(wire_io));
  assign wire_io = (io_oe & io_out) | (~io_oe & h_io);

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  function automatic logic [7:0] f(input logic [24:0] a);
    return {a[24], a[6:0]} ^ 8'h3C;
  endfunction

  // array side answers at once or after a stall of five cycles
  always @(negedge i_clock) begin
    wt <= (mem_req === 1'b1 && !i_mem_ack) ? wt + 1 : 0;
    i_mem_ack <= 1'b0;
    if (mem_req === 1'b1 && !i_mem_ack && wt >= (slow ? 5 : 0)) begin
      i_mem_ack <= 1'b1;
      i_mem_data <= f(mem_addr);
      aq.push_back(mem_addr);
    end
    n_clr <= n_clr + int'(clr === 1'b1);
    n_susp <= n_susp + int'(susp === 1'b1);
  end

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input logic q);
    host.cs(1'b0);
    host.xfer(op, q, 1'b0, r);
    host.cs(1'b1);
  endtask

  task automatic setp(input logic [7:0] p);
    host.cs(1'b0);
    host.xfer(8'hC0, 1'b1, 1'b0, r);
    host.xfer(p, 1'b1, 1'b0, r);
    host.cs(1'b1);
  endtask

  task automatic t_init;
    chk(25'({qpi, params, wbits}), 25'h7);
  endtask

  // lone reset opcode and spi parameter write must both be dropped
  task automatic t_refused;
    cmd(8'h99, 1'b0);
    chk(25'(n_clr), 25'h0);
    host.cs(1'b0);
    host.xfer(8'hC0, 1'b0, 1'b0, r);
    host.xfer(8'h33, 1'b0, 1'b0, r);
    host.cs(1'b1);
    chk(25'(params), 25'h0);
  endtask

  task automatic t_spi_setup;
    host.cs(1'b0);
    host.xfer(8'h77, 1'b0, 1'b0, r);
    repeat (3) host.xfer(8'h00, 1'b1, 1'b0, r);
    host.xfer(8'h20, 1'b1, 1'b0, r);
    host.cs(1'b1);
    chk(25'(wbits), 25'h2);
    cmd(8'h38, 1'b0);
    chk(25'(qpi), 25'h1);
    chk(25'(wbits), 25'h2);
  endtask

  // start two bytes before the window end so the third byte wraps
  task automatic t_wrap(input logic [7:0] p, input logic [7:0] op, input int nd, input int w);
    logic [23:0] s;
    logic [24:0] e;
    s = 24'hF5A5C0 + 24'(w - 2);
    setp(p);
    chk(25'(params), 25'(p));
    aq.delete();
    host.cs(1'b0);
    host.xfer(op, 1'b1, 1'b0, r);
    for (int i = 2; i >= 0; i--)
      host.xfer(s[8*i +: 8], 1'b1, 1'b0, r);
    repeat (nd) host.dummy();
    for (int k = 0; k < 4; k++) begin
      host.xfer(8'h00, 1'b1, 1'b1, r);
      e = {op == 8'h8D, 24'hF5A5C0 + 24'((w - 2 + k) % w)};
      chk(aq[k], e);
      chk(25'(r), 25'(f(e)));
    end
    host.cs(1'b1);
  endtask

  task automatic t_qpi_off;
    cmd(8'hFF, 1'b1);
    chk(25'({qpi, wbits}), 25'h2);
  endtask

  task automatic t_table;
    logic [7:0] t[25];
    t = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01,
          8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00,
          8'h00, 8'hFF, 8'hFF};
    host.cs(1'b0);
    host.xfer(8'h5A, 1'b0, 1'b0, r);
    repeat (3) host.xfer(8'h00, 1'b0, 1'b0, r);
    repeat (8) host.dummy();
    foreach (t[i]) begin
      host.xfer(8'h00, 1'b0, 1'b1, r);
      chk(25'(r), 25'(t[i]));
    end
    host.cs(1'b1);
    chk(25'(io_oe), 25'h0);
  endtask

  task automatic t_suspend;
    for (int i = 0; i < 3; i++) begin
      @(negedge i_clock);
      i_wip = (i != 2);
      i_suspend = (i == 1);
      cmd(8'h75, 1'b0);
      chk(25'(n_susp), 25'h1);
    end
  endtask

  task automatic t_reset(input logic q);
    int n0;
    @(negedge i_clock);
    i_wip = 1'b0;
    n0 = n_clr;
    if (q) begin
      cmd(8'h38, 1'b0);
      setp(8'h33);
    end
    cmd(8'h66, q);
    cmd(8'h99, q);
    chk(25'(n_clr), 25'(n0 + 1));
    chk(25'(busy), 25'h1);
    cmd(8'h38, 1'b0);
    chk(25'(qpi), 25'h0);
    for (int i = 0; i < 4000 && busy === 1'b1; i++)
      @(negedge i_clock);
    chk(25'(busy), 25'h0);
    chk(25'({qpi, params, wbits}), 25'h7);
  endtask

  initial begin
    i_rst = 1'b1;
    i_suspend = 1'b0;
    i_wip = 1'b0;
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clock);
    t_init;
    t_refused;
    t_spi_setup;
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      t_wrap(cp[i], cop[i], cnd[i], cw[i]);
    end
    t_qpi_off;
    t_table;
    t_suspend;
    t_reset(1'b0);
    t_reset(1'b1);
    test_done;
  end

  initial begin
    #400000;
    err_count++;
    test_done;
  end
endmodule
